// [testbench/drive_bus_monitor.sv]
`timescale 1ns/1ps
module drive_bus_monitor
   import drive_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic wr_valid,
   input wire logic [15:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [15:0] report_word,
   input wire logic [15:0] active_mode
);
   logic [15:0] last_cmd_q;
   logic cw;
   logic mw;
   logic jw;
   logic live;
   logic [6:0] st;
   logic [6:0] sx;
   assign cw = wr_valid && wr_addr == ADDR_COMMAND_WORD;
   assign mw = wr_valid && wr_addr == ADDR_MODE_SELECT;
   assign jw = wr_valid && wr_addr == ADDR_JOG_REQUEST;
   assign st = report_word[6:0] & 7'h6f;
   // Bit 5 means nothing in disabled and fault
   assign sx = report_word[6:0] & 7'h4f;
   assign live = !report_word[3] && (report_word[6] || report_word[0]);
   always_ff @(posedge clk) begin
      if (srst) begin
         last_cmd_q <= 16'h0000;
      end else if (cw) begin
         last_cmd_q <= wr_data;
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (srst);
   chk_reserved_zero: assert property (cw |-> wr_data[15:9] == 7'h00)
      else $error("reserved command bits set");
   chk_jog_order: assert property (jw |-> wr_data <= JOG_REQUEST_MAX ##2 mw)
      else $error("jog write not followed by mode write");
   chk_shutdown_ready: assert property (cw && wr_data[2:0] == 3'h6 && live
      && report_word[4] && st[5] |-> ##2 st == 7'h21)
      else $error("shutdown did not reach ready");
   chk_switch_on: assert property (cw && wr_data[3:0] == 4'h7 && st == 7'h21
      |-> ##2 st == 7'h23)
      else $error("switch on failed");
   chk_enable_op: assert property (cw && wr_data[3:0] == 4'hf && st == 7'h23
      |-> ##2 st == 7'h27)
      else $error("enable operation failed");
   chk_voltage_off: assert property (cw && !wr_data[1] && live |-> ##2 sx == 7'h40)
      else $error("disable voltage failed");
   chk_quick_stop: assert property (cw && wr_data[2:1] == 2'h1 && st == 7'h27
      |-> ##2 st == 7'h07)
      else $error("quick stop failed");
   chk_fault_clear: assert property (cw && wr_data[7] && !last_cmd_q[7]
      && sx == 7'h0f |-> ##2 sx == 7'h40)
      else $error("fault clear failed");
   chk_halt_follow: assert property (cw |-> ##2 report_word[8] == $past(wr_data[8], 2))
      else $error("halt report wrong");
   chk_mode_refused: assert property (mw && st != 7'h27 |=> $stable(active_mode))
      else $error("mode taken outside operation");
   chk_mode_range: assert property (mw && $signed(wr_data) > MODE_MAX
      |=> $stable(active_mode))
      else $error("out of range mode taken");
   cover property (cw && wr_data[7]);
   cover property (mw && st == 7'h27);
   cover property (jw);
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench
   import drive_cmd_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic enable_in, fault_clear_in, init_done, voltage_ok, fault_event, fault_cause;
   logic standstill, target_reached, cmd_valid, jog_valid, mode_valid, busy;
   logic halt_request, mode_start;
   logic [2:0] jog_request, mode_bits, jog_bits;
   logic [7:0] state_onehot;
   logic [15:0] cmd_word, report_seen;
   logic signed [15:0] jog_mode, mode_code;
   int failures = 0;
   int compares = 0;
   int start_count = 0;
   int start_base;
   typedef struct {logic [15:0] cmd; logic [7:0] st; logic [6:0] rpt;} row_s;
   row_s rows [17];
   drive_bus_if bus_if();
   always #20 clk = ~clk;
   always @(posedge clk) if (mode_start === 1'b1) start_count <= start_count + 1;
   drive_state_command_logic i_drive_state_command_logic (.clk(clk), .srst(srst),
      .bus(bus_if.device), .enable_in(enable_in), .fault_clear_in(fault_clear_in),
      .init_done(init_done), .voltage_ok(voltage_ok), .fault_event(fault_event),
      .fault_cause_present(fault_cause), .motion_standstill(standstill),
      .target_reached(target_reached), .halt_request(halt_request), .jog_request(jog_request),
      .mode_bits(mode_bits), .mode_start(mode_start), .state_onehot(state_onehot));
   fieldbus_master_end i_fieldbus_master_end (.clk(clk), .srst(srst), .bus(bus_if.master),
      .cmd_valid(cmd_valid), .cmd_word(cmd_word), .jog_valid(jog_valid), .jog_bits(jog_bits),
      .jog_mode(jog_mode), .mode_valid(mode_valid), .mode_code(mode_code), .busy(busy),
      .report_seen(report_seen));
   drive_bus_monitor i_drive_bus_monitor (.clk(clk), .srst(srst), .wr_valid(bus_if.wr_valid),
      .wr_addr(bus_if.wr_addr), .wr_data(bus_if.wr_data), .report_word(bus_if.report_word),
      .active_mode(bus_if.active_mode));

   task automatic close_out();
      $display("Compares %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 50) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k == 50) begin
         failures++;
         close_out();
      end
      repeat (n) @(posedge clk);
      #1;
   endtask

   // sel: bit 0 command, bit 1 mode, bit 2 jog then mode
   task automatic send(input logic [2:0] sel, input logic [15:0] w);
      cmd_word = w;
      mode_code = w;
      jog_mode = w;
      {jog_valid, mode_valid, cmd_valid} = sel;
      @(posedge clk);
      #1;
      {jog_valid, mode_valid, cmd_valid} = 3'h0;
      settle(3);
   endtask

   task automatic expect_state(input logic [7:0] st, input logic [6:0] rpt);
      logic [6:0] mask;
      mask = (rpt[6] || rpt[3]) ? 7'h4f : 7'h6f;
      check({8'h00, state_onehot}, {8'h00, st});
      check({9'h000, bus_if.report_word[6:0] & mask}, {9'h000, rpt});
   endtask

   task automatic raise_fault();
      fault_event = 1'b1;
      settle(3);
      fault_event = 1'b0;
      settle(3);
      expect_state(ST_FAULT, 7'h0f);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      close_out();
   end

   initial begin
      {enable_in, fault_clear_in, fault_event, fault_cause, target_reached} = 5'h00;
      {cmd_valid, jog_valid, mode_valid} = 3'h0;
      init_done = 1'b1;
      voltage_ok = 1'b1;
      standstill = 1'b1;
      cmd_word = 16'h0000;
      jog_bits = 3'h0;
      jog_mode = 16'h0000;
      mode_code = 16'h0000;
      rows = '{'{16'h0006, ST_READY, 7'h21}, '{16'h0007, ST_SWITCHED_ON, 7'h23},
         '{16'h000f, ST_OPERATION_ENABLE, 7'h27}, '{16'h0007, ST_SWITCHED_ON, 7'h23},
         '{16'h000f, ST_OPERATION_ENABLE, 7'h27}, '{16'h0006, ST_READY, 7'h21},
         '{16'h0007, ST_SWITCHED_ON, 7'h23}, '{16'h0006, ST_READY, 7'h21},
         '{16'h0000, ST_SWITCH_ON_DISABLED, 7'h40}, '{16'h0006, ST_READY, 7'h21},
         '{16'h0003, ST_SWITCH_ON_DISABLED, 7'h40}, '{16'h0076, ST_READY, 7'h21},
         '{16'h0077, ST_SWITCHED_ON, 7'h23}, '{16'h007f, ST_OPERATION_ENABLE, 7'h27},
         '{16'h000b, ST_QUICK_STOP, 7'h07}, '{16'h0006, ST_QUICK_STOP, 7'h07},
         '{16'h000d, ST_SWITCH_ON_DISABLED, 7'h40}};
      repeat (10) @(posedge clk);
      #1;
      srst = 1'b0;
      settle(3);
      expect_state(ST_SWITCH_ON_DISABLED, 7'h40);
      check({13'h0000, jog_request}, JOG_REQUEST_RESET);
      check(bus_if.active_mode, MODE_SELECT_RESET);
      for (int i = 0; i < 17; i++) begin
         send(3'h1, rows[i].cmd);
         expect_state(rows[i].st, rows[i].rpt);
         check({13'h0000, mode_bits}, {13'h0000, rows[i].cmd[6:4]});
      end
      $display("Command table done");
      send(3'h1, 16'h0106);
      check({15'h0000, bus_if.report_word[SW_HALT_ACTIVE]}, 16'h0001);
      send(3'h1, 16'h0000);
      check({15'h0000, halt_request}, 16'h0000);
      voltage_ok = 1'b0;
      settle(2);
      send(3'h1, 16'h0006);
      expect_state(ST_SWITCH_ON_DISABLED, 7'h40);
      check({15'h0000, bus_if.report_word[SW_VOLTAGE_OK]}, 16'h0000);
      voltage_ok = 1'b1;
      enable_in = 1'b1;
      settle(3);
      expect_state(ST_OPERATION_ENABLE, 7'h27);
      enable_in = 1'b0;
      settle(3);
      expect_state(ST_READY, 7'h21);
      $display("Halt and input test done");
      send(3'h2, MODE_PROFILE_VELOCITY);
      check(bus_if.active_mode, MODE_SELECT_RESET);
      send(3'h1, 16'h0007);
      send(3'h1, 16'h000f);
      send(3'h2, 16'h0007);
      check(bus_if.active_mode, MODE_SELECT_RESET);
      standstill = 1'b0;
      send(3'h2, MODE_PROFILE_VELOCITY);
      check(bus_if.active_mode, MODE_PROFILE_VELOCITY);
      send(3'h2, MODE_HOMING);
      check(bus_if.active_mode, MODE_PROFILE_VELOCITY);
      standstill = 1'b1;
      settle(3);
      send(3'h2, MODE_HOMING);
      check(bus_if.active_mode, MODE_HOMING);
      start_base = start_count;
      standstill = 1'b0;
      send(3'h1, 16'h001f);
      check(16'(start_count - start_base), 16'h0001);
      standstill = 1'b1;
      settle(3);
      jog_bits = 3'h5;
      send(3'h4, MODE_JOG);
      check({13'h0000, jog_request}, 16'h0005);
      check(bus_if.active_mode, MODE_JOG);
      $display("Mode test done");
      raise_fault();
      send(3'h1, 16'h0080);
      expect_state(ST_SWITCH_ON_DISABLED, 7'h40);
      // Fault event is ignored while disabled, so leave that state first
      send(3'h1, 16'h0086);
      expect_state(ST_READY, 7'h21);
      raise_fault();
      send(3'h1, 16'h0080);
      expect_state(ST_FAULT, 7'h0f);
      send(3'h1, 16'h0000);
      send(3'h1, 16'h0080);
      expect_state(ST_SWITCH_ON_DISABLED, 7'h40);
      send(3'h1, 16'h0006);
      raise_fault();
      fault_clear_in = 1'b1;
      settle(3);
      expect_state(ST_SWITCH_ON_DISABLED, 7'h40);
      $display("Fault test done");
      fault_clear_in = 1'b0;
      send(3'h1, 16'h0006);
      send(3'h1, 16'h0007);
      send(3'h1, 16'h000f);
      standstill = 1'b0;
      send(3'h2, MODE_PROFILE_VELOCITY);
      check({15'h0000, bus_if.report_word[SW_MODE_END]}, 16'h0000);
      fault_cause = 1'b1;
      raise_fault();
      check({15'h0000, bus_if.report_word[SW_MODE_ERROR]}, 16'h0001);
      fault_clear_in = 1'b1;
      settle(3);
      fault_clear_in = 1'b0;
      send(3'h1, 16'h0006);
      send(3'h1, 16'h0007);
      send(3'h1, 16'h000f);
      send(3'h2, MODE_HOMING);
      check(bus_if.active_mode, MODE_PROFILE_VELOCITY);
      check({15'h0000, bus_if.report_word[SW_MODE_ERROR]}, 16'h0001);
      fault_cause = 1'b0;
      standstill = 1'b1;
      target_reached = 1'b1;
      settle(3);
      check({15'h0000, bus_if.report_word[SW_MODE_ERROR]}, 16'h0000);
      check({15'h0000, bus_if.report_word[SW_MODE_END]}, 16'h0001);
      check({15'h0000, bus_if.report_word[SW_TARGET_REACHED]}, 16'h0001);
      target_reached = 1'b0;
      send(3'h2, MODE_HOMING);
      check(bus_if.active_mode, MODE_HOMING);
      $display("Mode error test done");
      init_done = 1'b0;
      srst = 1'b1;
      settle(2);
      expect_state(ST_NOT_READY, 7'h00);
      check(bus_if.active_mode, MODE_SELECT_RESET);
      srst = 1'b0;
      settle(3);
      expect_state(ST_NOT_READY, 7'h00);
      init_done = 1'b1;
      settle(3);
      expect_state(ST_SWITCH_ON_DISABLED, 7'h40);
      $display("Reset test done");
      close_out();
   end
endmodule

// [verilog/drive_bus_if.sv]
`timescale 1ns/1ps
interface drive_bus_if;
   logic wr_valid;
   logic [15:0] wr_addr;
   logic [15:0] wr_data;
   logic [15:0] report_word;
   logic [15:0] active_mode;
   modport device (input wr_valid, input wr_addr, input wr_data,
      output report_word, output active_mode);
   modport master (output wr_valid, output wr_addr, output wr_data,
      input report_word, input active_mode);
endinterface

// [verilog/drive_cmd_pkg.sv]
package drive_cmd_pkg;
   // Parameter addresses on the fieldbus
   localparam logic [15:0] ADDR_COMMAND_WORD = 16'h1b02;
   localparam logic [15:0] ADDR_STATE_REPORT = 16'h1b04;
   localparam logic [15:0] ADDR_MODE_SELECT = 16'h1b06;
   localparam logic [15:0] ADDR_JOG_REQUEST = 16'h1b12;
   localparam logic [15:0] COMMAND_WORD_RESET = 16'h0000;
   localparam logic [15:0] JOG_REQUEST_RESET = 16'h0000;
   localparam logic [15:0] MODE_SELECT_RESET = 16'h0000;
   localparam logic [15:0] JOG_REQUEST_MAX = 16'h0007;
   localparam logic [15:0] COMMAND_RESERVED_MASK = 16'hfe00;
   // Command word fields
   localparam int CW_SWITCH_ON = 0;
   localparam int CW_ENABLE_VOLTAGE = 1;
   localparam int CW_QUICK_STOP = 2;
   localparam int CW_ENABLE_OPERATION = 3;
   localparam int CW_MODE_START = 4;
   localparam int CW_FAULT_CLEAR = 7;
   localparam int CW_HALT = 8;
   // Report word fields
   localparam int SW_VOLTAGE_OK = 4;
   localparam int SW_HALT_ACTIVE = 8;
   localparam int SW_TARGET_REACHED = 10;
   localparam int SW_MODE_ERROR = 13;
   localparam int SW_MODE_END = 14;
   // Mode codes
   localparam logic signed [15:0] MODE_NONE = 16'sh0000;
   localparam logic signed [15:0] MODE_PROFILE_POSITION = 16'sh0001;
   localparam logic signed [15:0] MODE_PROFILE_VELOCITY = 16'sh0003;
   localparam logic signed [15:0] MODE_HOMING = 16'sh0006;
   localparam logic signed [15:0] MODE_JOG = -16'sh0001;
   localparam logic signed [15:0] MODE_MIN = -16'sh0006;
   localparam logic signed [15:0] MODE_MAX = 16'sh0006;

   typedef enum logic [7:0] {
      ST_NOT_READY = 8'h01,
      ST_SWITCH_ON_DISABLED = 8'h02,
      ST_READY = 8'h04,
      ST_SWITCHED_ON = 8'h08,
      ST_OPERATION_ENABLE = 8'h10,
      ST_QUICK_STOP = 8'h20,
      ST_FAULT_REACTION = 8'h40,
      ST_FAULT = 8'h80
   } drive_state_e;

   typedef enum logic [3:0] {
      MS_IDLE = 4'h1,
      MS_ARMED = 4'h2,
      MS_RUNNING = 4'h4,
      MS_ERROR = 4'h8
   } mode_state_e;
endpackage

// [verilog/drive_state_command_logic.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Enable and fault-clear inputs move state
// - Only bits 0-3 and 7 drive transitions
// - Sixteen-bit command word, fixed bit layout
// - Shutdown, switch on, enable operation encodings
// - Voltage off or quick stop leaves operation
// - Don't-care bits ignored per command
// - Bit 8 set triggers halt
// - Master writes reserved bits 9-15 as zero
// - Bits 4-6 belong to selected mode
// - One mode at a time; switch after end
// - Standstill terminates the mode
// - Error blocks mode until cause cleared
// - State change and mode start are separate, except a bit 4 start write that also encodes a transition
// - Mode select write starts a mode; position and homing are only armed
// - Master writes jog bits before mode
// - Jog request 0 to 7, default 0
// - Bit 4 starts position and homing
// - State shown in report bits 0-3,5,6
// - No ready state without bus voltage (voltage checked on shutdown from switch on disabled and on enable input rise)
module drive_state_command_logic
   import drive_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   drive_bus_if.device bus,
   input wire logic enable_in,
   input wire logic fault_clear_in,
   input wire logic init_done,
   input wire logic voltage_ok,
   input wire logic fault_event,
   input wire logic fault_cause_present,
   input wire logic motion_standstill,
   input wire logic target_reached,
   output logic halt_request,
   output logic [2:0] jog_request,
   output logic [2:0] mode_bits,
   output logic mode_start,
   output logic [7:0] state_onehot
);
   drive_state_e state_q, state_d;
   mode_state_e mstate_q;
   logic [15:0] command_q, jog_q, mode_act_q, report_q;
   logic enable_prev_q, fclear_prev_q;
   logic halt_q, start_q;
   logic cw_wr, mode_wr, jog_wr;
   logic fclear_rise;
   logic [6:0] sbits;

   function automatic logic [6:0] state_bits(input drive_state_e s);
      case (s)
         ST_SWITCH_ON_DISABLED: state_bits = 7'b1000000;
         ST_READY: state_bits = 7'b0100001;
         ST_SWITCHED_ON: state_bits = 7'b0100011;
         ST_OPERATION_ENABLE: state_bits = 7'b0100111;
         ST_QUICK_STOP: state_bits = 7'b0000111;
         ST_FAULT_REACTION: state_bits = 7'b0001111;
         ST_FAULT: state_bits = 7'b0001111;
         default: state_bits = 7'b0000000;
      endcase
   endfunction

   assign cw_wr = bus.wr_valid && (bus.wr_addr == ADDR_COMMAND_WORD);
   assign mode_wr = bus.wr_valid && (bus.wr_addr == ADDR_MODE_SELECT);
   assign jog_wr = bus.wr_valid && (bus.wr_addr == ADDR_JOG_REQUEST);
   assign sbits = state_bits(state_q);
   assign fclear_rise = cw_wr && bus.wr_data[CW_FAULT_CLEAR]
      && !command_q[CW_FAULT_CLEAR];

   // Reserved bits stored as written; master keeps them zero
   always_ff @(posedge clk) begin
      if (srst) begin
         command_q <= COMMAND_WORD_RESET;
      end else if (cw_wr) begin
         command_q <= bus.wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         jog_q <= JOG_REQUEST_RESET;
      end else if (jog_wr && bus.wr_data <= JOG_REQUEST_MAX) begin
         jog_q <= bus.wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         enable_prev_q <= 1'b0;
         fclear_prev_q <= 1'b0;
      end else begin
         enable_prev_q <= enable_in;
         fclear_prev_q <= fault_clear_in;
      end
   end

   // Whole write decoded at once, so one transition per write
   always_comb begin
      logic [15:0] w;
      w = bus.wr_data;
      state_d = state_q;
      if (fault_event && state_q != ST_FAULT && state_q != ST_NOT_READY
            && state_q != ST_SWITCH_ON_DISABLED) begin
         state_d = ST_FAULT_REACTION;
      end else begin
         case (state_q)
            ST_NOT_READY: begin
               if (init_done) state_d = ST_SWITCH_ON_DISABLED;
            end
            ST_FAULT_REACTION: state_d = ST_FAULT;
            ST_FAULT: begin
               if (fclear_rise || (fault_clear_in && !fclear_prev_q)) begin
                  state_d = ST_SWITCH_ON_DISABLED;
               end
            end
            default: begin
               if (cw_wr) begin
                  if (!w[CW_ENABLE_VOLTAGE]) begin
                     if (state_q != ST_SWITCH_ON_DISABLED)
                        state_d = ST_SWITCH_ON_DISABLED;
                  end else if (!w[CW_QUICK_STOP]) begin
                     if (state_q == ST_OPERATION_ENABLE)
                        state_d = ST_QUICK_STOP;
                     else if (state_q == ST_READY || state_q == ST_SWITCHED_ON)
                        state_d = ST_SWITCH_ON_DISABLED;
                  end else if (!w[CW_SWITCH_ON]) begin
                     if (state_q == ST_SWITCH_ON_DISABLED) begin
                        if (voltage_ok) state_d = ST_READY;
                     end else if (state_q != ST_QUICK_STOP) begin
                        state_d = ST_READY;
                     end
                  end else if (state_q == ST_READY) begin
                     state_d = ST_SWITCHED_ON;
                  end else if (state_q == ST_SWITCHED_ON && w[CW_ENABLE_OPERATION]) begin
                     state_d = ST_OPERATION_ENABLE;
                  end else if ((state_q == ST_OPERATION_ENABLE
                        || state_q == ST_QUICK_STOP) && !w[CW_ENABLE_OPERATION]) begin
                     state_d = ST_SWITCHED_ON;
                  end else if (state_q == ST_QUICK_STOP) begin
                     state_d = ST_OPERATION_ENABLE;
                  end
               end else if (enable_in && !enable_prev_q) begin
                  if (state_q == ST_SWITCH_ON_DISABLED || state_q == ST_READY
                        || state_q == ST_SWITCHED_ON) begin
                     if (voltage_ok) state_d = ST_OPERATION_ENABLE;
                  end
               end else if (!enable_in && enable_prev_q) begin
                  if (state_q == ST_OPERATION_ENABLE || state_q == ST_SWITCHED_ON)
                     state_d = ST_READY;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= ST_NOT_READY;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         halt_q <= 1'b0;
      end else if (cw_wr) begin
         halt_q <= bus.wr_data[CW_HALT];
      end
   end

   // Mode sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         mstate_q <= MS_IDLE;
         mode_act_q <= MODE_SELECT_RESET;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         case (mstate_q)
            MS_IDLE: begin
               // Mode write is its own action, only in operation enable
               if (mode_wr && state_q == ST_OPERATION_ENABLE && !cw_wr
                     && $signed(bus.wr_data) >= MODE_MIN
                     && $signed(bus.wr_data) <= MODE_MAX) begin
                  mode_act_q <= bus.wr_data;
                  if ($signed(bus.wr_data) == MODE_PROFILE_POSITION
                        || $signed(bus.wr_data) == MODE_HOMING) begin
                     mstate_q <= MS_ARMED;
                  end else begin
                     mstate_q <= MS_RUNNING;
                     start_q <= 1'b1;
                  end
               end
            end
            MS_ARMED: begin
               if (state_q != ST_OPERATION_ENABLE) begin
                  mstate_q <= MS_IDLE;
               end else if (cw_wr && bus.wr_data[CW_MODE_START]) begin
                  mstate_q <= MS_RUNNING;
                  start_q <= 1'b1;
               end
            end
            MS_RUNNING: begin
               if (state_q == ST_FAULT_REACTION || state_q == ST_FAULT) begin
                  mstate_q <= MS_ERROR;
               end else if (motion_standstill && !start_q) begin
                  mstate_q <= MS_IDLE;
               end
            end
            MS_ERROR: begin
               if (!fault_cause_present && state_q != ST_FAULT
                     && state_q != ST_FAULT_REACTION) begin
                  mstate_q <= MS_IDLE;
               end
            end
            default: mstate_q <= MS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         report_q <= 16'h0000;
      end else begin
         report_q <= {1'b0, mstate_q != MS_RUNNING, mstate_q == MS_ERROR, 2'b00,
            target_reached && mstate_q == MS_IDLE, 1'b0, halt_q, 1'b0,
            sbits[6:5], voltage_ok, sbits[3:0]};
      end
   end

   assign bus.report_word = report_q;
   assign bus.active_mode = mode_act_q;
   assign halt_request = halt_q;
   assign jog_request = jog_q[2:0];
   assign mode_bits = command_q[6:4];
   assign mode_start = start_q;
   assign state_onehot = state_q;
endmodule

// [verilog/fieldbus_master_end.sv]
`timescale 1ns/1ps
// Master end: turns user requests into ordered parameter writes.
module fieldbus_master_end
   import drive_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   drive_bus_if.master bus,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_word,
   input wire logic jog_valid,
   input wire logic [2:0] jog_bits,
   input wire logic signed [15:0] jog_mode,
   input wire logic mode_valid,
   input wire logic signed [15:0] mode_code,
   output logic busy,
   output logic [15:0] report_seen
);
   typedef enum logic [2:0] {
      MM_IDLE = 3'h1,
      MM_JOG_BITS = 3'h2,
      MM_MODE = 3'h4
   } master_state_e;
   master_state_e mm_q;
   logic wr_q;
   logic [15:0] addr_q, data_q, mode_hold_q, report_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         mm_q <= MM_IDLE;
         wr_q <= 1'b0;
         addr_q <= 16'h0000;
         data_q <= 16'h0000;
         mode_hold_q <= 16'h0000;
      end else begin
         wr_q <= 1'b0;
         case (mm_q)
            MM_IDLE: begin
               if (cmd_valid) begin
                  wr_q <= 1'b1;
                  addr_q <= ADDR_COMMAND_WORD;
                  data_q <= cmd_word & ~COMMAND_RESERVED_MASK;
               end else if (jog_valid) begin
                  wr_q <= 1'b1;
                  addr_q <= ADDR_JOG_REQUEST;
                  data_q <= {13'h0000, jog_bits};
                  mode_hold_q <= jog_mode;
                  mm_q <= MM_JOG_BITS;
               end else if (mode_valid) begin
                  mode_hold_q <= mode_code;
                  mm_q <= MM_MODE;
               end
            end
            MM_JOG_BITS: mm_q <= MM_MODE;
            MM_MODE: begin
               wr_q <= 1'b1;
               addr_q <= ADDR_MODE_SELECT;
               data_q <= mode_hold_q;
               mm_q <= MM_IDLE;
            end
            default: mm_q <= MM_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         report_q <= 16'h0000;
      end else begin
         report_q <= bus.report_word;
      end
   end

   assign bus.wr_valid = wr_q;
   assign bus.wr_addr = addr_q;
   assign bus.wr_data = data_q;
   assign busy = (mm_q != MM_IDLE);
   assign report_seen = report_q;
endmodule
